// ==== logic/rcsr_defs.svh ====
// Purpose: Offsets, field positions, reset values for the reduced interface register bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Definitions only
`ifndef RCSR_DEFS_SVH
`define RCSR_DEFS_SVH

// Register indices
`define RCSR_IDX_GOOD_LO      12'h63c
`define RCSR_IDX_GOOD_HI      12'h63d
`define RCSR_IDX_CRC_ERR      12'h63e
`define RCSR_IDX_CTRL         12'h648
`define RCSR_IDX_STAT         12'h649
`define RCSR_IDX_OVRD         12'h64a
// Counter clearing sequence locations
`define RCSR_IDX_SEQ0         12'h612
`define RCSR_IDX_SEQ1         12'h613
`define RCSR_IDX_SEQ2         12'h614
// Control register fields
`define RCSR_CTRL_TXD_NODLY   10
`define RCSR_CTRL_HF_HI       9
`define RCSR_CTRL_HF_LO       7
`define RCSR_CTRL_ENABLE      6
`define RCSR_CTRL_BYPASS      5
`define RCSR_CTRL_XTAL        4
`define RCSR_CTRL_REV1        1
`define RCSR_CTRL_ENH         0
`define RCSR_CTRL_WMASK       16'h07f3
`define RCSR_CTRL_RESET       16'h0120
// Status fields
`define RCSR_STAT_UNF         1
`define RCSR_STAT_OVF         0
// Override fields
`define RCSR_OVRD_TX_DLL      10
`define RCSR_OVRD_RX_DLL      9
`define RCSR_OVRD_WMASK       16'h07ff
`define RCSR_OVRD_RESET       16'h0010
// Strap patterns
`define RCSR_STRAP_ENABLE     2'b01
`define RCSR_STRAP_XTAL       3'b010
`define RCSR_STRAP_TX_DLL     3'b011
`define RCSR_STRAP_RX_DLL     3'b010
// Bus responses
`define RCSR_RESP_OKAY        2'b00
`define RCSR_RESP_SLVERR      2'b10

`endif

// ==== logic/rcsr_pkg.sv ====
// Purpose: Types for the reduced interface register bank
// Assumes: Nothing beyond the defs header
// Notes:   Clearing sequence tracker states
package rcsr_pkg;
  // Progress through the three-location counter clearing read sequence
  typedef enum logic [1:0] {
    RCSR_SEQ_IDLE = 2'b00,
    RCSR_SEQ_ONE  = 2'b01,
    RCSR_SEQ_TWO  = 2'b10
  } rcsr_seq_t;
endpackage

// ==== logic/rcsr_regs.sv ====
// Purpose: Reduced interface config/status registers and receive packet counters on AXI4-Lite
// Assumes: Inputs synchronous to REF_CLK; straps stable while reset is held
// Notes:   Byte address = 4 * register index; data in low 16 bits, upper bits read zero
// Functional notes
// RULE1 - CRC error count cleared by read sequence
// RULE2 - Good packet count cleared same way
// RULE3 - Bit ten disables transmit data delay
// RULE4 - Bits nine to seven set threshold
// RULE5 - Bit six enables interface, strap reset
// RULE6 - Bit five bypasses async FIFO
// RULE7 - Bit four crystal select, strap reset
// RULE8 - Bit one selects revision one mode
// RULE9 - Bit zero enables enhanced mode
// RULE10 - Underflow flag cleared by status read
// RULE11 - Overflow flag cleared by status read
// RULE12 - Transmit DLL clock select, strap reset
// RULE13 - Receive DLL clock select, strap reset
// RULE14 - Error flags sticky until status read
// RULE15 - Software preserves reserved override bits
`timescale 1ns/1ps
`include "rcsr_defs.svh"
`default_nettype none

module rcsr_regs
#(
  parameter int ADDR_W = 14
)
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // Strap levels on the receive data lines
  input  wire logic              RECEIVE_LINE2_BOOTSTRAP,
  input  wire logic              RECEIVE_LINE1_BOOTSTRAP,
  input  wire logic              RECEIVE_LINE0_BOOTSTRAP,
  // Data path events
  input  wire logic              RX_GOOD_PACKET,
  input  wire logic              RX_CRC_ERROR_PACKET,
  input  wire logic              FIFO_UNDERFLOW_EVENT,
  input  wire logic              FIFO_OVERFLOW_EVENT,
  // Configuration outputs
  output logic                   TXD_DELAY_DISABLE,
  output logic [2:0]             RECEIVE_FIFO_HALF_FULL_THRESHOLD,
  output logic                   REDUCED_INTERFACE_ENABLE,
  output logic                   ASYNC_FIFO_BYPASS,
  output logic                   CRYSTAL_FREQUENCY_SELECT,
  output logic                   REVISION_ONE_MODE,
  output logic                   ENHANCED_MODE,
  output logic                   TRANSMIT_DLL_CLOCK_SELECT,
  output logic                   RECEIVE_DLL_CLOCK_SELECT
);

  // Register storage; all of it uses the synchronous reset
  // Strap-dependent bits take their strap value one edge after release
  logic [15:0] ctrl;          // Control register
  logic [15:0] ovrd;          // Clock override register
  logic        unf_flag;      // Sticky underflow flag
  logic        ovf_flag;      // Sticky overflow flag
  logic [15:0] crc_err_cnt;   // CRC error packet count
  logic [31:0] good_cnt;      // Good packet count
  logic        strap_load;    // High in the first cycle after reset release
  rcsr_pkg::rcsr_seq_t seq;   // Clearing sequence progress

  // Write channel holding state
  // Address and data may come in either order; each waits here for the other
  logic              aw_held;   // Write address captured
  logic [ADDR_W-1:0] aw_addr;   // Captured write address
  logic              w_held;    // Write data captured
  logic [31:0]       w_data;    // Captured write data
  logic [3:0]        w_strb;    // Captured byte strobes

  // Straps as a vector
  // Pins are read only at the load edge; later strap changes are ignored
  wire logic [2:0] straps = {RECEIVE_LINE2_BOOTSTRAP, RECEIVE_LINE1_BOOTSTRAP, RECEIVE_LINE0_BOOTSTRAP};

  // Strap-derived reset values
  // Each strap term only sets a bit that the fixed reset value leaves clear
  wire logic [15:0] ctrl_strap =
    `RCSR_CTRL_RESET
    | (16'(straps[2:1] == `RCSR_STRAP_ENABLE) << `RCSR_CTRL_ENABLE)        // [RULE5]
    | (16'(straps == `RCSR_STRAP_XTAL) << `RCSR_CTRL_XTAL);                // [RULE7]
  wire logic [15:0] ovrd_strap =
    `RCSR_OVRD_RESET
    | (16'(straps == `RCSR_STRAP_TX_DLL) << `RCSR_OVRD_TX_DLL)             // [RULE12]
    | (16'(straps == `RCSR_STRAP_RX_DLL) << `RCSR_OVRD_RX_DLL);            // [RULE13]

  // Write decode: address and data both present, response slot free
  // A waiting response holds the next write back, so one write is in flight
  wire logic        wr_go     = aw_held && w_held && !BVALID;
  wire logic [11:0] wr_idx    = 12'(aw_addr >> 2);
  wire logic        wr_ctrl   = wr_go && (wr_idx == `RCSR_IDX_CTRL);
  wire logic        wr_ovrd   = wr_go && (wr_idx == `RCSR_IDX_OVRD);
  wire logic        wr_known  = (wr_idx == `RCSR_IDX_CTRL) || (wr_idx == `RCSR_IDX_OVRD)
                                || (wr_idx == `RCSR_IDX_STAT) || (wr_idx == `RCSR_IDX_CRC_ERR)
                                || (wr_idx == `RCSR_IDX_GOOD_LO) || (wr_idx == `RCSR_IDX_GOOD_HI);
  // Byte-lane mask over the low 16 bits
  wire logic [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // Read decode: a read is taken when no answer is pending
  // Side effects of a read land on the edge its address is taken
  wire logic        rd_go     = ARVALID && !RVALID;
  wire logic [11:0] rd_idx    = 12'(ARADDR >> 2);
  wire logic        rd_stat   = rd_go && (rd_idx == `RCSR_IDX_STAT);
  wire logic        rd_seq0   = rd_go && (rd_idx == `RCSR_IDX_SEQ0);
  wire logic        rd_seq1   = rd_go && (rd_idx == `RCSR_IDX_SEQ1);
  wire logic        rd_seq2   = rd_go && (rd_idx == `RCSR_IDX_SEQ2);
  // Third read of the sequence completes it
  wire logic        cnt_clear = rd_seq2 && (seq == rcsr_pkg::RCSR_SEQ_TWO);

  // Read data selection
  // Unmapped indices read zero and answer with an error code
  logic [15:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    case (rd_idx)
      `RCSR_IDX_CTRL:    rd_word = ctrl;
      `RCSR_IDX_OVRD:    rd_word = ovrd;
      `RCSR_IDX_STAT:    rd_word = {14'h0000, unf_flag, ovf_flag};
      `RCSR_IDX_CRC_ERR: rd_word = crc_err_cnt;
      `RCSR_IDX_GOOD_LO: rd_word = good_cnt[15:0];
      `RCSR_IDX_GOOD_HI: rd_word = good_cnt[31:16];
      `RCSR_IDX_SEQ0,
      `RCSR_IDX_SEQ1,
      `RCSR_IDX_SEQ2:    rd_word = 16'h0000;  // Sequence locations read zero
      default:           rd_hit  = 1'b0;      // Unmapped
    endcase
  end

  // Handshake outputs
  // Write readies come straight from the holding flags, so each drops
  // the cycle after a capture and returns once the write is done
  assign AWREADY = !aw_held;
  assign WREADY  = !w_held;
  assign ARREADY = !RVALID;

  // Write address capture
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      aw_held <= 1'b0;
    else if (AWVALID && !aw_held)
      aw_held <= 1'b1;
    else if (wr_go)
      aw_held <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      aw_addr <= '0;
    else if (AWVALID && !aw_held)
      aw_addr <= AWADDR;
  end

  // Write data capture
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      w_held <= 1'b0;
    else if (WVALID && !w_held)
      w_held <= 1'b1;
    else if (wr_go)
      w_held <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (WVALID && !w_held)
    begin
      w_data <= WDATA;
      w_strb <= WSTRB;
    end
  end

  // Write response
  // Unmapped places answer with an error and change nothing
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      BVALID <= 1'b0;
      BRESP  <= `RCSR_RESP_OKAY;
    end
    else if (wr_go)
    begin
      BVALID <= 1'b1;
      BRESP  <= wr_known ? `RCSR_RESP_OKAY : `RCSR_RESP_SLVERR;
    end
    else if (BREADY)
      BVALID <= 1'b0;
  end

  // Read response
  // Data stands with the valid flag until the master takes it
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `RCSR_RESP_OKAY;
    end
    else if (rd_go)
    begin
      RVALID <= 1'b1;
      RDATA  <= {16'h0000, rd_word};
      RRESP  <= rd_hit ? `RCSR_RESP_OKAY : `RCSR_RESP_SLVERR;
    end
    else if (RREADY)
      RVALID <= 1'b0;
  end

  // Marks the cycle after reset release, when straps are caught
  // Straps must be settled while reset is held for this to be safe
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      strap_load <= 1'b1;
    else
      strap_load <= 1'b0;
  end

  // Control register: strap load, then masked byte writes
  // Reserved bits are outside the write mask and keep their reset value
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      ctrl <= `RCSR_CTRL_RESET;                                           // [RULE3] [RULE4] [RULE6]
    else if (strap_load)
      ctrl <= ctrl_strap;                                                 // [RULE5] [RULE7]
    else if (wr_ctrl)
      ctrl <= (ctrl & ~(lane_mask & `RCSR_CTRL_WMASK))
              | (w_data[15:0] & lane_mask & `RCSR_CTRL_WMASK);
  end

  // Override register: strap load, then masked byte writes
  // Bits 8:0 take whatever is written; keeping bit 4 set is software's job
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      ovrd <= `RCSR_OVRD_RESET;
    else if (strap_load)
      ovrd <= ovrd_strap;                                                 // [RULE12] [RULE13]
    else if (wr_ovrd)
      ovrd <= (ovrd & ~(lane_mask & `RCSR_OVRD_WMASK))
              | (w_data[15:0] & lane_mask & `RCSR_OVRD_WMASK);
  end

  // Sticky FIFO flags; a new event wins over the read clear
  // so an error in the cycle of a status read is reported by the next one
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      unf_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end
    else
    begin
      unf_flag <= FIFO_UNDERFLOW_EVENT || (unf_flag && !rd_stat);        // [RULE10] [RULE14]
      ovf_flag <= FIFO_OVERFLOW_EVENT || (ovf_flag && !rd_stat);         // [RULE11] [RULE14]
    end
  end

  // Clearing sequence tracker; any other read breaks the sequence
  // A repeated first location restarts it instead of breaking it
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      seq <= rcsr_pkg::RCSR_SEQ_IDLE;
    else if (rd_go)
    begin
      case (seq)
        rcsr_pkg::RCSR_SEQ_IDLE: seq <= rd_seq0 ? rcsr_pkg::RCSR_SEQ_ONE : rcsr_pkg::RCSR_SEQ_IDLE;
        rcsr_pkg::RCSR_SEQ_ONE:  seq <= rd_seq1 ? rcsr_pkg::RCSR_SEQ_TWO
                                        : (rd_seq0 ? rcsr_pkg::RCSR_SEQ_ONE : rcsr_pkg::RCSR_SEQ_IDLE);
        rcsr_pkg::RCSR_SEQ_TWO:  seq <= rd_seq0 ? rcsr_pkg::RCSR_SEQ_ONE : rcsr_pkg::RCSR_SEQ_IDLE;
        default:                 seq <= rcsr_pkg::RCSR_SEQ_IDLE;
      endcase
    end
  end

  // Packet counters; an event in the clearing cycle counts as one
  // Counters wrap at full scale; the good count has no snapshot, so its
  // halves can be read across an increment
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      crc_err_cnt <= 16'h0000;
      good_cnt    <= 32'h0000_0000;
    end
    else
    begin
      if (cnt_clear)
        crc_err_cnt <= {15'h0000, RX_CRC_ERROR_PACKET};                  // [RULE1]
      else if (RX_CRC_ERROR_PACKET)
        crc_err_cnt <= crc_err_cnt + 16'h0001;
      if (cnt_clear)
        good_cnt <= {31'h0000_0000, RX_GOOD_PACKET};                     // [RULE2]
      else if (RX_GOOD_PACKET)
        good_cnt <= good_cnt + 32'h0000_0001;
    end
  end

  // Configuration outputs straight from the registers
  // They move only at reset, on a register write or at the strap load
  assign TXD_DELAY_DISABLE                = ctrl[`RCSR_CTRL_TXD_NODLY];     // [RULE3]
  assign RECEIVE_FIFO_HALF_FULL_THRESHOLD = ctrl[`RCSR_CTRL_HF_HI:`RCSR_CTRL_HF_LO]; // [RULE4]
  assign REDUCED_INTERFACE_ENABLE         = ctrl[`RCSR_CTRL_ENABLE];        // [RULE5]
  assign ASYNC_FIFO_BYPASS                = ctrl[`RCSR_CTRL_BYPASS];        // [RULE6]
  assign CRYSTAL_FREQUENCY_SELECT         = ctrl[`RCSR_CTRL_XTAL];          // [RULE7]
  assign REVISION_ONE_MODE                = ctrl[`RCSR_CTRL_REV1];          // [RULE8]
  assign ENHANCED_MODE                    = ctrl[`RCSR_CTRL_ENH];           // [RULE9]
  assign TRANSMIT_DLL_CLOCK_SELECT        = ovrd[`RCSR_OVRD_TX_DLL];        // [RULE12]
  assign RECEIVE_DLL_CLOCK_SELECT         = ovrd[`RCSR_OVRD_RX_DLL];        // [RULE13]

endmodule

`default_nettype wire

// ==== test/rcsr_regs_monitor.sv ====
// Purpose: Reset, strap and bus checks on the reduced interface register bank
// Assumes: Sees only top-level ports of rcsr_regs
// Notes:   Bound below the module
`timescale 1ns/1ps
`default_nettype none
module rcsr_regs_monitor
(
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        RECEIVE_LINE2_BOOTSTRAP,
  input wire logic        RECEIVE_LINE1_BOOTSTRAP,
  input wire logic        RECEIVE_LINE0_BOOTSTRAP,
  input wire logic        TXD_DELAY_DISABLE,
  input wire logic [2:0]  RECEIVE_FIFO_HALF_FULL_THRESHOLD,
  input wire logic        REDUCED_INTERFACE_ENABLE,
  input wire logic        ASYNC_FIFO_BYPASS,
  input wire logic        CRYSTAL_FREQUENCY_SELECT,
  input wire logic        REVISION_ONE_MODE,
  input wire logic        ENHANCED_MODE,
  input wire logic        TRANSMIT_DLL_CLOCK_SELECT,
  input wire logic        RECEIVE_DLL_CLOCK_SELECT
);
  // All configuration outputs packed together
  wire [10:0] cfg = {TXD_DELAY_DISABLE, RECEIVE_FIFO_HALF_FULL_THRESHOLD, REDUCED_INTERFACE_ENABLE,
    ASYNC_FIFO_BYPASS, CRYSTAL_FREQUENCY_SELECT, REVISION_ONE_MODE, ENHANCED_MODE,
    TRANSMIT_DLL_CLOCK_SELECT, RECEIVE_DLL_CLOCK_SELECT};
  // Strap pattern as sampled
  wire [2:0]  strap = {RECEIVE_LINE2_BOOTSTRAP, RECEIVE_LINE1_BOOTSTRAP, RECEIVE_LINE0_BOOTSTRAP};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // First edge with reset released
  sequence s_release;
    $rose(RST_B);
  endsequence
  // Read address accepted
  sequence s_ar_taken;
    ARVALID && ARREADY;
  endsequence
  AST_RST_CFG: assert property (s_release |-> cfg == 11'h120)
    else $error("config outputs differ from reset values");
  AST_STRAP_CTRL: assert property (s_release |=>
    (REDUCED_INTERFACE_ENABLE == ($past(strap[2:1]) == 2'b01))
    && (CRYSTAL_FREQUENCY_SELECT == ($past(strap) == 3'b010)))
    else $error("strap load of control bits wrong");
  AST_STRAP_DLL: assert property (s_release |=>
    (TRANSMIT_DLL_CLOCK_SELECT == ($past(strap) == 3'b011))
    && (RECEIVE_DLL_CLOCK_SELECT == ($past(strap) == 3'b010)))
    else $error("strap load of clock selects wrong");
  AST_CFG_HOLD: assert property ($past(RST_B, 2) && !$rose(BVALID) |-> $stable(cfg))
    else $error("config changed without a write");
  AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read response dropped early");
  AST_AR_ANSWER: assert property (s_ar_taken |=> RVALID)
    else $error("read not answered next cycle");
  AST_RD_UPPER: assert property (RVALID |-> RDATA[31:16] == 16'h0000 && RRESP inside {2'b00, 2'b10})
    else $error("read upper half or code wrong");
  AST_B_CODE: assert property (BVALID |-> BRESP inside {2'b00, 2'b10})
    else $error("write response code wrong");
endmodule
bind rcsr_regs rcsr_regs_monitor u_mon (.REF_CLK(REF_CLK), .RST_B(RST_B), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .RECEIVE_LINE2_BOOTSTRAP(RECEIVE_LINE2_BOOTSTRAP),
  .RECEIVE_LINE1_BOOTSTRAP(RECEIVE_LINE1_BOOTSTRAP), .RECEIVE_LINE0_BOOTSTRAP(RECEIVE_LINE0_BOOTSTRAP),
  .TXD_DELAY_DISABLE(TXD_DELAY_DISABLE), .RECEIVE_FIFO_HALF_FULL_THRESHOLD(RECEIVE_FIFO_HALF_FULL_THRESHOLD),
  .REDUCED_INTERFACE_ENABLE(REDUCED_INTERFACE_ENABLE), .ASYNC_FIFO_BYPASS(ASYNC_FIFO_BYPASS),
  .CRYSTAL_FREQUENCY_SELECT(CRYSTAL_FREQUENCY_SELECT), .REVISION_ONE_MODE(REVISION_ONE_MODE),
  .ENHANCED_MODE(ENHANCED_MODE), .TRANSMIT_DLL_CLOCK_SELECT(TRANSMIT_DLL_CLOCK_SELECT),
  .RECEIVE_DLL_CLOCK_SELECT(RECEIVE_DLL_CLOCK_SELECT));
`default_nettype wire

// ==== test/rcsr_mac_model.sv ====
// Purpose: Receive side event source standing in for the MAC data path
// Assumes: Requests come from the bench one cycle ahead
// Notes:   Bit 0 good packet, 1 CRC error, 2 underflow, 3 overflow
`timescale 1ns/1ps
`default_nettype none
module rcsr_mac_model
(
  input  wire logic       clk,
  input  wire logic [3:0] req,
  output logic      [3:0] ev
);
  // Registered so every event is a clean one-cycle pulse
  always_ff @(posedge clk)
  begin
    ev <= req;
  end
endmodule
`default_nettype wire

// ==== test/rcsr_regs_bench.sv ====
// Purpose: Self-checking bench for the reduced interface register bank
// Assumes: AXI4-Lite master tasks, LFSR stimulus from a fixed seed
// Notes:   Straps swept over all patterns with a reset each
`timescale 1ns/1ps
`include "rcsr_defs.svh"
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rcsr_regs_bench;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, lag;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, lf;
  logic [3:0]  wstrb, mreq;
  logic [2:0]  strap;
  logic [15:0] rdat, d, e, c, n, k;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid, txd, en, byp, xt, rev, enh, txdll, rxdll;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  ev;
  wire  [2:0]  thr;
  int          err_total, n_tests, cyc, i;
  rcsr_regs uut (.REF_CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .RECEIVE_LINE2_BOOTSTRAP(strap[2]), .RECEIVE_LINE1_BOOTSTRAP(strap[1]),
    .RECEIVE_LINE0_BOOTSTRAP(strap[0]), .RX_GOOD_PACKET(ev[0]), .RX_CRC_ERROR_PACKET(ev[1]),
    .FIFO_UNDERFLOW_EVENT(ev[2]), .FIFO_OVERFLOW_EVENT(ev[3]), .TXD_DELAY_DISABLE(txd),
    .RECEIVE_FIFO_HALF_FULL_THRESHOLD(thr), .REDUCED_INTERFACE_ENABLE(en), .ASYNC_FIFO_BYPASS(byp),
    .CRYSTAL_FREQUENCY_SELECT(xt), .REVISION_ONE_MODE(rev), .ENHANCED_MODE(enh),
    .TRANSMIT_DLL_CLOCK_SELECT(txdll), .RECEIVE_DLL_CLOCK_SELECT(rxdll));
  rcsr_mac_model u_mac (.clk(clk), .req(mreq), .ev(ev));
  // Clock at 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Stimulus source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected control and override values after reset with a strap pattern
  function automatic logic [15:0] exp_ctrl(input logic [2:0] s);
    exp_ctrl = `RCSR_CTRL_RESET | ((s[2:1] == `RCSR_STRAP_ENABLE) ? 16'h0040 : 16'h0000)
      | ((s == `RCSR_STRAP_XTAL) ? 16'h0010 : 16'h0000);
  endfunction
  function automatic logic [15:0] exp_ovrd(input logic [2:0] s);
    exp_ovrd = `RCSR_OVRD_RESET | ((s == `RCSR_STRAP_TX_DLL) ? 16'h0400 : 16'h0000)
      | ((s == `RCSR_STRAP_RX_DLL) ? 16'h0200 : 16'h0000);
  endfunction
  // Write one register; holds each channel until taken; lag holds the response back a cycle
  task automatic wr(input logic [11:0] idx, input logic [15:0] v);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !lag;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask
  // Read one register into rdat and rs
  task automatic rdg(input logic [11:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= !lag;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rdat = rdata[15:0];
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chkrd(input logic [11:0] idx, input logic [15:0] x);
    rdg(idx);
    `CHK(rdat, x)
  endtask
  // Reset for 8 cycles with a strap pattern
  task automatic rst(input logic [2:0] s);
    @(posedge clk);
    strap <= s;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Ask the MAC model for j event pulses
  task automatic pulse(input logic [3:0] r, input logic [15:0] j);
    repeat (j)
    begin
      @(posedge clk);
      mreq <= r;
      @(posedge clk);
      mreq <= 4'h0;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict;
    end
  end
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, lag, awaddr, araddr, wdata, wstrb, mreq, strap} = '0;
    lf = 32'h3758;
    // Reset values for every strap pattern, mid-run resets included
    for (i = 0; i < 8; i++)
    begin
      rst(i[2:0]);
      chkrd(`RCSR_IDX_CTRL, exp_ctrl(i[2:0]));
      chkrd(`RCSR_IDX_OVRD, exp_ovrd(i[2:0]));
      chkrd(`RCSR_IDX_STAT, 16'h0000);
      chkrd(`RCSR_IDX_CRC_ERR, 16'h0000);
    end
    $display("test reset_straps done");
    // Random and corner writes, checked at pins; control also by read-back
    for (i = 0; i < 16; i++)
    begin
      lf = lfsr_next(lf);
      d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lf[15:0];
      lag = lf[20];
      wr(`RCSR_IDX_CTRL, d);
      `CHK({txd, thr, en, byp, xt, rev, enh}, {d[10:4], d[1:0]})
      c = d & `RCSR_CTRL_WMASK;
      chkrd(`RCSR_IDX_CTRL, c);
      e = (d & 16'h0600) | 16'h0010;
      wr(`RCSR_IDX_OVRD, e);
      `CHK({txdll, rxdll, rs}, {e[10:9], `RCSR_RESP_OKAY})
    end
    $display("test config_writes done");
    // Sticky flags cleared by reading status
    pulse(4'h4, 16'd1);
    chkrd(`RCSR_IDX_STAT, 16'h0002);
    chkrd(`RCSR_IDX_STAT, 16'h0000);
    pulse(4'h8, 16'd3);
    chkrd(`RCSR_IDX_STAT, 16'h0001);
    pulse(4'hc, 16'd1);
    chkrd(`RCSR_IDX_STAT, 16'h0003);
    chkrd(`RCSR_IDX_STAT, 16'h0000);
    // Underflow lands on the very edge the status read is taken
    fork
      rdg(`RCSR_IDX_STAT);
      begin
        mreq <= 4'h4;
        @(posedge clk);
        mreq <= 4'h0;
      end
    join
    `CHK(rdat, 16'h0000)
    chkrd(`RCSR_IDX_STAT, 16'h0002);
    $display("test fifo_flags done");
    // Counters, a broken clearing sequence, then a proper one
    lf = lfsr_next(lf);
    n = {14'h0000, lf[1:0]} + 16'h0001;
    k = {14'h0000, lf[3:2]};
    pulse(4'h3, n);
    pulse(4'h1, k);
    chkrd(`RCSR_IDX_CRC_ERR, n);
    chkrd(`RCSR_IDX_GOOD_LO, n + k);
    chkrd(`RCSR_IDX_GOOD_HI, 16'h0000);
    chkrd(`RCSR_IDX_SEQ0, 16'h0000);
    chkrd(`RCSR_IDX_CTRL, c);
    chkrd(`RCSR_IDX_SEQ1, 16'h0000);
    chkrd(`RCSR_IDX_SEQ2, 16'h0000);
    chkrd(`RCSR_IDX_CRC_ERR, n);
    chkrd(`RCSR_IDX_SEQ0, 16'h0000);
    chkrd(`RCSR_IDX_SEQ1, 16'h0000);
    chkrd(`RCSR_IDX_SEQ2, 16'h0000);
    chkrd(`RCSR_IDX_CRC_ERR, 16'h0000);
    chkrd(`RCSR_IDX_GOOD_LO, 16'h0000);
    $display("test counters done");
    // Unmapped and read-only places
    rdg(12'h100);
    `CHK(rs, `RCSR_RESP_SLVERR)
    wr(12'h100, 16'hffff);
    `CHK(rs, `RCSR_RESP_SLVERR)
    wr(`RCSR_IDX_STAT, 16'hffff);
    chkrd(`RCSR_IDX_STAT, 16'h0000);
    chkrd(`RCSR_IDX_CTRL, c);
    $display("test refusals done");
    print_verdict;
  end
endmodule
`default_nettype wire
